// ---- eps_pkg.sv ----
// package: register map, vectors and source layout of the exception block
package eps_pkg;
    // ****************************************
    // register map (apb byte addresses)
    // ****************************************
    localparam logic [7:0] ADDR_PEND_LOW = 8'h00;
    localparam logic [7:0] ADDR_PEND_MID = 8'h04;
    localparam logic [7:0] ADDR_PEND_HIGH = 8'h08;
    localparam logic [7:0] ADDR_BRK_FLAG_CTRL = 8'h0c;
    localparam logic [7:0] ADDR_CPU_STATE = 8'h10;
    localparam logic [7:0] RESET_PEND = 8'h00;
    localparam logic [7:0] RESET_BRK_FLAG_CTRL = 8'h00;
    localparam int BIT_BREAK_CLEAR_EN = 0;
    // ****************************************
    // sources: index n is pending flag n (1..22)
    // ****************************************
    localparam int NUM_SRC = 22;
    localparam int SRC_CH0 = 3;
    localparam int SRC_ADC = 15;
    localparam int SRC_TIM2_OVF = 18;
    localparam int SRC_WAKEUP = 19;
    // ****************************************
    // vectors
    // ****************************************
    localparam logic [15:0] VEC_RESET = 16'hfffe;
    localparam logic [15:0] VEC_SWI = 16'hfffc;
    localparam logic [15:0] VEC_FLAG1 = 16'hfffa;
    localparam logic [15:0] VEC_STEP = 16'h0002;
    localparam logic [15:0] PC_HW_ADJUST = 16'h0001;
    typedef enum logic [1:0] {EPS_RUN, EPS_WAIT, EPS_STOP} eps_pwr_t;
    // vector of flag n: fffa minus two per step below flag 1; flag 2 gets fff8
    function automatic logic [15:0] eps_vector(input int n);
        eps_vector = VEC_FLAG1 - VEC_STEP * 16'(n - 1);
    endfunction
endpackage

// ---- eps_arbiter.sv ----
// module: fixed priority pick among enabled pending sources
`timescale 1ns/1ps
module eps_arbiter import eps_pkg::*; #(
    parameter int N = NUM_SRC
) (
    input wire logic [N:1] req,
    output logic found,
    output logic [4:0] winner
);
    // ****************************************
    // lowest index wins
    // ****************************************
    always_comb begin
        found = 1'b0;
        winner = 5'h00;
        for (int i = N; i >= 1; i--) begin
            if (req[i]) begin
                found = 1'b1;
                winner = 5'(i);
            end
        end
    end
endmodule // eps_arbiter

// ---- eps_sync.sv ----
// module: two flip-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
module eps_sync #(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule // eps_sync

// ---- exception_priority_status.sv ----
// module: exception priority, vector and pending-flag status logic
`timescale 1ns/1ps
module exception_priority_status import eps_pkg::*; #(
    parameter int N = NUM_SRC
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [N:1] srcFlag,
    input wire logic [N:1] srcEnable,
    input wire logic resetReq,
    input wire logic breakReq,
    input wire logic insnDone,
    input wire logic swiExec,
    input wire logic waitExec,
    input wire logic stopExec,
    input wire logic rtiExec,
    input wire logic [15:0] programCounter,
    input wire logic serviced,
    output logic takeReq,
    output logic [15:0] vectorAddr,
    output logic [15:0] stackedPc,
    output logic pushUpperIndex,
    output logic maskBit,
    output logic cpuClockEn,
    output logic periphClockEn,
    output logic flagClearAllow
);
    // ****************************************
    // pin-level inputs pass a synchroniser
    // ****************************************
    logic [N:1] flagSync;
    logic breakSync;
    eps_sync #(.W(N + 1)) u_sync (
        .mclk(mclk),
        .rst_b(rst_b),
        .d({breakReq, srcFlag}),
        .q({breakSync, flagSync})
    );
    // ****************************************
    // enabled requests and priority pick
    // ****************************************
    logic [N:1] enabledReq;
    logic hwFound;
    logic [4:0] hwWinner;
    assign enabledReq = flagSync & srcEnable;
    eps_arbiter #(.N(N)) u_arb (
        .req(enabledReq),
        .found(hwFound),
        .winner(hwWinner)
    );
    // ****************************************
    // state
    // ****************************************
    logic [7:0] pendLow_reg, pendLow_next;
    logic [7:0] pendMid_reg, pendMid_next;
    logic [7:0] pendHigh_reg, pendHigh_next;
    logic brkCtrl_reg, brkCtrl_next;
    logic inBreak_reg, inBreak_next;
    logic mask_reg, mask_next;
    logic latched_reg, latched_next;
    logic [4:0] latchedSrc_reg, latchedSrc_next;
    logic take_reg, take_next;
    logic [15:0] vec_reg, vec_next;
    logic [15:0] spc_reg, spc_next;
    eps_pwr_t pwr_reg, pwr_next;
    logic [31:0] rdata_reg, rdata_next;
    logic ready_reg, ready_next;
    logic err_reg, err_next;
    logic cpuEn_reg, cpuEn_next;
    logic periphEn_reg, periphEn_next;
    logic clrAllow_reg, clrAllow_next;
    logic apbAccess;
    assign apbAccess = psel && penable && !ready_reg;
    // ****************************************
    // status registers and break protection
    // ****************************************
    always_comb begin
        pendLow_next = {flagSync[6:1], 2'b00};
        pendMid_next = flagSync[14:7];
        pendHigh_next = flagSync[22:15];
        brkCtrl_next = brkCtrl_reg;
        inBreak_next = inBreak_reg;
        // a write lands at the edge where pready is sampled high
        if (psel && penable && ready_reg && pwrite
            && paddr == ADDR_BRK_FLAG_CTRL) begin
            brkCtrl_next = pwdata[BIT_BREAK_CLEAR_EN];
        end
        // break is left on return from the trap taken for it
        if (take_reg && vec_reg == VEC_SWI && breakSync) begin
            inBreak_next = 1'b1;
        end else if (rtiExec) begin
            inBreak_next = 1'b0;
        end
        clrAllow_next = !inBreak_next || brkCtrl_next;
    end
    // protection is a level; other modules gate both clear steps on it,
    // so a first step taken before break cannot finish inside it
    // ****************************************
    // exception sequencing
    // ****************************************
    always_comb begin
        mask_next = mask_reg;
        latched_next = latched_reg;
        latchedSrc_next = latchedSrc_reg;
        take_next = 1'b0;
        vec_next = vec_reg;
        spc_next = spc_reg;
        pwr_next = pwr_reg;
        if (!latched_reg && hwFound && !mask_reg) begin
            latched_next = 1'b1;
            latchedSrc_next = hwWinner;
        end
        if (latched_reg && mask_reg) begin
            latched_next = 1'b0;
        end
        if (resetReq) begin
            // every reset source lands on one vector, no ranking
            take_next = 1'b1;
            vec_next = VEC_RESET;
            mask_next = 1'b1;
            latched_next = 1'b0;
            pwr_next = EPS_RUN;
        end else if (breakSync && (insnDone || pwr_reg != EPS_RUN)) begin
            take_next = 1'b1;
            vec_next = VEC_SWI;
            spc_next = programCounter - PC_HW_ADJUST;
            mask_next = 1'b1;
            pwr_next = EPS_RUN;
        end else if (swiExec) begin
            take_next = 1'b1;
            vec_next = VEC_SWI;
            spc_next = programCounter;
            mask_next = 1'b1;
        end else if (latched_reg && !mask_reg
                     && (insnDone || pwr_reg != EPS_RUN)) begin
            take_next = 1'b1;
            vec_next = eps_vector(int'(latchedSrc_reg));
            spc_next = programCounter - PC_HW_ADJUST;
            mask_next = 1'b1;
            latched_next = 1'b0;
            pwr_next = EPS_RUN;
        end else if (waitExec) begin
            mask_next = 1'b0;
            pwr_next = EPS_WAIT;
        end else if (stopExec) begin
            mask_next = 1'b0;
            pwr_next = EPS_STOP;
        end else if (rtiExec) begin
            mask_next = 1'b0;
        end
        if (serviced) begin
            latched_next = 1'b0;
        end
        // clock gates are registered so the outputs leave a flip-flop
        cpuEn_next = pwr_next == EPS_RUN;
        periphEn_next = pwr_next != EPS_STOP;
    end
    // ****************************************
    // apb slave: one wait state, zero on unmapped
    // ****************************************
    always_comb begin
        ready_next = apbAccess;
        err_next = 1'b0;
        rdata_next = rdata_reg;
        if (apbAccess && !pwrite) begin
            unique case (paddr)
                ADDR_PEND_LOW: rdata_next = {24'h000000, pendLow_reg};
                ADDR_PEND_MID: rdata_next = {24'h000000, pendMid_reg};
                ADDR_PEND_HIGH: rdata_next = {24'h000000, pendHigh_reg};
                ADDR_BRK_FLAG_CTRL: rdata_next = {31'h00000000, brkCtrl_reg};
                ADDR_CPU_STATE: rdata_next = {28'h0000000, inBreak_reg,
                    mask_reg, 2'(pwr_reg)};
                default: rdata_next = 32'h00000000;
            endcase
        end
    end
    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pendLow_reg <= RESET_PEND;
            pendMid_reg <= RESET_PEND;
            pendHigh_reg <= RESET_PEND;
            brkCtrl_reg <= RESET_BRK_FLAG_CTRL[0];
            inBreak_reg <= 1'b0;
            mask_reg <= 1'b1;
            latched_reg <= 1'b0;
            latchedSrc_reg <= 5'h00;
            take_reg <= 1'b0;
            vec_reg <= VEC_RESET;
            spc_reg <= 16'h0000;
            pwr_reg <= EPS_RUN;
            rdata_reg <= 32'h00000000;
            ready_reg <= 1'b0;
            err_reg <= 1'b0;
            cpuEn_reg <= 1'b1;
            periphEn_reg <= 1'b1;
            clrAllow_reg <= 1'b1;
        end else begin
            pendLow_reg <= pendLow_next;
            pendMid_reg <= pendMid_next;
            pendHigh_reg <= pendHigh_next;
            brkCtrl_reg <= brkCtrl_next;
            inBreak_reg <= inBreak_next;
            mask_reg <= mask_next;
            latched_reg <= latched_next;
            latchedSrc_reg <= latchedSrc_next;
            take_reg <= take_next;
            vec_reg <= vec_next;
            spc_reg <= spc_next;
            pwr_reg <= pwr_next;
            rdata_reg <= rdata_next;
            ready_reg <= ready_next;
            err_reg <= err_next;
            cpuEn_reg <= cpuEn_next;
            periphEn_reg <= periphEn_next;
            clrAllow_reg <= clrAllow_next;
        end
    end
    // ****************************************
    // outputs
    // ****************************************
    assign prdata = rdata_reg;
    assign pready = ready_reg;
    assign pslverr = err_reg;
    assign takeReq = take_reg;
    assign vectorAddr = vec_reg;
    assign stackedPc = spc_reg;
    // upper index stays off the stack for old code compatibility
    assign pushUpperIndex = 1'b0;
    assign maskBit = mask_reg;
    assign cpuClockEn = cpuEn_reg;
    assign periphClockEn = periphEn_reg;
    assign flagClearAllow = clrAllow_reg;
    // ****************************************
    // checks
    // ****************************************
    chk_swi_ignores_mask: assert property (
        @(posedge mclk) disable iff (!rst_b)
        swiExec && !resetReq && !breakSync |=> takeReq && vectorAddr == VEC_SWI
        && stackedPc == $past(programCounter))
        else $error("software trap not taken with its pc");
    chk_hw_pc_minus: assert property (
        @(posedge mclk) disable iff (!rst_b)
        takeReq && vectorAddr != VEC_SWI && vectorAddr != VEC_RESET
        |-> stackedPc == $past(programCounter) - PC_HW_ADJUST)
        else $error("hardware entry stacked wrong pc");
    chk_mask_blocks_hw: assert property (
        @(posedge mclk) disable iff (!rst_b)
        $past(mask_reg) && $past(!swiExec) && $past(!breakSync)
        && $past(!resetReq) |-> !takeReq)
        else $error("hardware source taken while masked");
    chk_wakeup_vector: assert property (
        @(posedge mclk) disable iff (!rst_b)
        take_next && latchedSrc_reg == 5'(SRC_WAKEUP) && !resetReq
        && !breakSync && !swiExec |=> vectorAddr == 16'hffd6)
        else $error("wakeup vector wrong");
    chk_low_zero_bits: assert property (
        @(posedge mclk) disable iff (!rst_b)
        pendLow_reg[1:0] == 2'b00 && pendHigh_reg == $past(flagSync[22:15]))
        else $error("status register contents wrong");
    chk_reset_top: assert property (
        @(posedge mclk) disable iff (!rst_b)
        resetReq |=> takeReq && vectorAddr == VEC_RESET && maskBit)
        else $error("reset not taken first");
    chk_wait_mask: assert property (
        @(posedge mclk) disable iff (!rst_b)
        waitExec && !resetReq && !breakSync && !swiExec && !take_next
        |=> !maskBit && !cpuClockEn && periphClockEn)
        else $error("wait entry wrong");
    chk_entry_sets_mask: assert property (
        @(posedge mclk) disable iff (!rst_b)
        takeReq |-> maskBit ##1 (maskBit || $past(rtiExec)
        || $past(waitExec) || $past(stopExec)))
        else $error("mask not set on entry");
    chk_break_protect: assert property (
        @(posedge mclk) disable iff (!rst_b)
        inBreak_reg && !brkCtrl_reg |-> !flagClearAllow)
        else $error("flags clearable in break");
endmodule // exception_priority_status

// ---- eps_cpu_model.sv ----
// file: cpu core model giving instruction ends and service acks
`timescale 1ns/1ps
module eps_cpu_model (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic takeReq,
    output logic insnDone,
    output logic serviced
);
    // ****************************************
    // instruction pacing
    // ****************************************
    logic [1:0] phaseReg;
    // fixed four-cycle instructions; the block never sees a mid-insn end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            phaseReg <= 2'h0;
            insnDone <= 1'b0;
            serviced <= 1'b0;
        end else begin
            phaseReg <= phaseReg + 2'h1;
            insnDone <= (phaseReg == 2'h3);
            // ack right after the vector fetch and stacking
            serviced <= takeReq;
        end
    end
endmodule // eps_cpu_model

// ---- exception_priority_status_tb_top.sv ----
// file: self-checking bench for the exception priority block
`timescale 1ns/1ps
module exception_priority_status_tb_top import eps_pkg::*;;
    // ****************************************
    // signals
    // ****************************************
    logic mclk, rst_b, psel, penable, pwrite, pready, pslverr, takeReq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, d;
    logic [22:1] srcFlag, srcEnable;
    logic resetReq, breakReq, insnDone, swiExec, waitExec, stopExec;
    logic rtiExec, serviced, pushUpperIndex, maskBit, cpuClockEn;
    logic periphClockEn, flagClearAllow;
    logic [15:0] programCounter, vectorAddr, stackedPc;
    int errTotal, cmpCount, cycles;
    logic [22:1] pat [5];
    logic [15:0] vec [5];
    exception_priority_status dut_u (.mclk(mclk), .rst_b(rst_b),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .srcFlag(srcFlag), .srcEnable(srcEnable),
        .resetReq(resetReq), .breakReq(breakReq), .insnDone(insnDone),
        .swiExec(swiExec), .waitExec(waitExec), .stopExec(stopExec),
        .rtiExec(rtiExec), .programCounter(programCounter),
        .serviced(serviced), .takeReq(takeReq), .vectorAddr(vectorAddr),
        .stackedPc(stackedPc), .pushUpperIndex(pushUpperIndex),
        .maskBit(maskBit), .cpuClockEn(cpuClockEn),
        .periphClockEn(periphClockEn), .flagClearAllow(flagClearAllow));
    eps_cpu_model cpu_u (.mclk(mclk), .rst_b(rst_b), .takeReq(takeReq),
        .insnDone(insnDone), .serviced(serviced));
    always #20 mclk = ~mclk;
    // ****************************************
    // tasks
    // ****************************************
    task automatic closeOut();
        $display("comparisons %0d mismatches %0d", cmpCount, errTotal);
        if (errTotal == 0 && cmpCount > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
            input logic [31:0] g);
        cmpCount++;
        if (g !== e) begin
            errTotal++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chkBit(input string nm, input logic e, input logic g);
        chk(nm, {31'h0, e}, {31'h0, g});
    endtask
    // slave latency is not assumed: hold until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge mclk);
        end
        if (n == 50) begin
            errTotal++;
        end
        rd = prdata;
        chkBit("slave error", 1'b0, pslverr);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, d);
        chk($sformatf("reg %h", a), e, d);
    endtask
    task automatic strobe(input int k);
        @(posedge mclk);
        swiExec <= (k == 0);
        waitExec <= (k == 1);
        stopExec <= (k == 2);
        rtiExec <= (k == 3);
        @(posedge mclk);
        {swiExec, waitExec, stopExec, rtiExec} <= 4'h0;
    endtask
    task automatic takeChk(input logic [15:0] v, input logic [15:0] p,
            input logic cp);
        int n;
        n = 0;
        while (takeReq !== 1'b1 && n < 40) begin
            @(negedge mclk);
            n++;
        end
        if (n == 40) begin
            errTotal++;
        end
        chk("vector", {16'h0, v}, {16'h0, vectorAddr});
        if (cp) begin
            chk("stacked pc", {16'h0, p}, {16'h0, stackedPc});
        end
        chkBit("mask after entry", 1'b1, maskBit);
        // hand back on a rising edge so the caller drives there
        @(posedge mclk);
    endtask
    task automatic noTake();
        logic seen;
        seen = 1'b0;
        repeat (20) begin
            @(posedge mclk);
            seen = seen | (takeReq !== 1'b0);
        end
        chkBit("take seen", 1'b0, seen);
    endtask
    // ****************************************
    // sequence
    // ****************************************
    initial begin
        {mclk, rst_b, psel, penable, pwrite, resetReq, breakReq} = 7'h0;
        {swiExec, waitExec, stopExec, rtiExec} = 4'h0;
        {paddr, pwdata, srcFlag, srcEnable} = '0;
        programCounter = 16'h1234;
        pat = '{22'h5, 22'h4, 22'h4000, 22'h60000, 22'h40000};
        vec = '{16'hfffa, 16'hfff6, 16'hffde, 16'hffd8, 16'hffd6};
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        @(negedge mclk);
        chkBit("mask", 1'b1, maskBit);
        chkBit("upper index push", 1'b0, pushUpperIndex);
        apb(1'b1, 8'h04, 32'hff, d);
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h08, 32'h0);
        rd(8'h14, 32'h0);
        $display("test reset done");
        foreach (pat[i]) begin
            @(posedge mclk);
            srcFlag <= pat[i] ^ 22'h2aaaa8;
            repeat (5) @(posedge mclk);
            rd(8'h00, {24'h0, srcFlag[6:1], 2'h0});
            rd(8'h04, {24'h0, srcFlag[14:7]});
            rd(8'h08, {24'h0, srcFlag[22:15]});
        end
        srcFlag <= '0;
        $display("test status done");
        strobe(0);
        takeChk(VEC_SWI, 16'h1234, 1'b1);
        strobe(3);
        repeat (2) @(negedge mclk);
        chkBit("mask after return", 1'b0, maskBit);
        srcEnable <= '1;
        foreach (pat[i]) begin
            @(posedge mclk);
            srcFlag <= pat[i];
            takeChk(vec[i], 16'h1233, 1'b1);
            srcFlag <= '0;
            repeat (4) @(posedge mclk);
            strobe(3);
        end
        srcFlag <= '0;
        $display("test priority done");
        srcEnable <= ~22'h4000;
        srcFlag <= 22'h4000;
        noTake();
        srcFlag <= '0;
        srcEnable <= '1;
        strobe(0);
        takeChk(VEC_SWI, 16'h1234, 1'b1);
        srcFlag <= 22'h4;
        noTake();
        strobe(3);
        takeChk(16'hfff6, 16'h1233, 1'b1);
        srcFlag <= '0;
        repeat (4) @(posedge mclk);
        strobe(3);
        $display("test masking done");
        breakReq <= 1'b1;
        takeChk(VEC_SWI, 16'h0, 1'b0);
        breakReq <= 1'b0;
        @(negedge mclk);
        chkBit("clear allow", 1'b0, flagClearAllow);
        apb(1'b1, 8'h0c, 32'h1, d);
        @(negedge mclk);
        chkBit("clear allow", 1'b1, flagClearAllow);
        rd(8'h0c, 32'h1);
        apb(1'b1, 8'h0c, 32'h0, d);
        @(negedge mclk);
        chkBit("clear allow", 1'b0, flagClearAllow);
        strobe(3);
        repeat (2) @(negedge mclk);
        chkBit("clear allow", 1'b1, flagClearAllow);
        $display("test break done");
        strobe(0);
        takeChk(VEC_SWI, 16'h1234, 1'b1);
        strobe(1);
        repeat (2) @(negedge mclk);
        chkBit("mask", 1'b0, maskBit);
        chkBit("cpu clock", 1'b0, cpuClockEn);
        chkBit("periph clock", 1'b1, periphClockEn);
        rd(8'h10, 32'h1);
        srcFlag <= 22'h10;
        takeChk(16'hfff2, 16'h1233, 1'b1);
        srcFlag <= '0;
        repeat (4) @(posedge mclk);
        strobe(3);
        strobe(2);
        repeat (2) @(negedge mclk);
        chkBit("cpu clock", 1'b0, cpuClockEn);
        chkBit("mask", 1'b0, maskBit);
        @(posedge mclk);
        resetReq <= 1'b1;
        swiExec <= 1'b1;
        takeChk(VEC_RESET, 16'h0, 1'b0);
        resetReq <= 1'b0;
        swiExec <= 1'b0;
        $display("test low power done");
        closeOut();
    end
    // a hang is cut short well past the few hundred cycles needed
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            errTotal++;
            closeOut();
        end
    end
endmodule // exception_priority_status_tb_top
